// ### design/mire_interrupt_ctrl.sv
// Purpose: maskable interrupt request, enable and priority arbitration
// Assumes: source events and cpu strobes are one-cycle pulses on clock
// Notes:   reset_pin is arst_n; the other reset causes act synchronously
//
// Behaviour
// - nesting on: only strictly higher level nests
// - nesting off: every enabled source may nest
// - nesting on: equal or lower levels wait for completion
// - pick highest level, then lowest vector
// - each source has request, enable, priority
// - request byte 0 bit map, gaps zero
// - request byte 1 bit map, gaps zero
// - request byte 2 bit map, gaps zero
// - request byte 3 bit map, gaps zero
// - request byte 4 holds pwm and timer9
// - byte 4 top bits ignore writes, read one
// - request byte 4 resets to E0
// - request bytes clear on any reset cause
// - interrupt only when enable bit is one
// - enable byte 0 mirrors request byte 0
// - enable byte 1 mirrors request byte 1
// - enable byte 2 mirrors request byte 2
// - enable byte 3 mirrors request byte 3
// - enable bytes clear on any reset cause
// - accept clears request, master enable; nesting on: blocks levels
// - three levels per source, two-bit field
// - return re-allows levels, sets master enable

`timescale 1ns/1ps

module mire_interrupt_ctrl (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [23:0] src_event,
    input  wire logic        break_instruction,
    input  wire logic        watchdog_overflow,
    input  wire logic        opcode_trap,
    input  wire logic        int_ack,
    input  wire logic        return_from_interrupt,
    output logic             int_req,
    output logic      [4:0]  int_vector,
    output logic      [1:0]  int_level
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [39:0] req_q;
    logic [39:0] req_d;
    logic [39:0] en_q;
    logic [39:0] en_d;
    logic [47:0] prio_q;
    logic [47:0] prio_d;
    logic        nest_q;
    logic        nest_d;
    logic        mie_q;
    logic        mie_d;
    logic [2:0]  svc_q;
    logic [2:0]  svc_d;
    logic [3:0]  busy_q;
    logic [3:0]  busy_d;
    logic        int_req_q;
    logic [4:0]  vec_q;
    logic [1:0]  lvl_q;
    logic [7:0]  rdata_q;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire         soft_rst  = break_instruction | watchdog_overflow | opcode_trap;
    wire         in_req    = reg_addr < mire_pkg::OFS_EN0;
    wire         in_en     = (reg_addr >= mire_pkg::OFS_EN0) && (reg_addr < mire_pkg::OFS_PRIO0);
    wire         in_prio   = (reg_addr >= mire_pkg::OFS_PRIO0) && (reg_addr < mire_pkg::OFS_CTRL);
    wire         in_ctrl   = reg_addr == mire_pkg::OFS_CTRL;
    wire         in_stat   = reg_addr == mire_pkg::OFS_STAT;
    wire [4:0]   req_off   = reg_addr - mire_pkg::OFS_REQ0;
    wire [4:0]   en_off    = reg_addr - mire_pkg::OFS_EN0;
    wire [4:0]   prio_off  = reg_addr - mire_pkg::OFS_PRIO0;
    wire [5:0]   req_sh    = {req_off[2:0], 3'b000};
    wire [5:0]   en_sh     = {en_off[2:0], 3'b000};
    wire [5:0]   prio_sh   = {prio_off[2:0], 3'b000};
    wire [39:0]  wdata_40  = {5{reg_wdata}};
    wire [47:0]  wdata_48  = {6{reg_wdata}};

    // unimplemented flag bits never store; byte 4 top bits ignore writes
    wire [39:0]  req_wmask = (reg_wr && in_req) ?
                             ((mire_pkg::BYTE_MASK_40 << req_sh) & mire_pkg::FLAG_IMPL) : 40'h00_0000_0000;
    wire [39:0]  en_wmask  = (reg_wr && in_en) ?
                             ((mire_pkg::BYTE_MASK_40 << en_sh) & mire_pkg::FLAG_IMPL) : 40'h00_0000_0000;
    wire [47:0]  prio_wmask = (reg_wr && in_prio) ?
                              (mire_pkg::BYTE_MASK_48 << prio_sh) : 48'h0000_0000_0000;
    wire         wr_ctrl   = reg_wr && in_ctrl;

    // ------------------------------------------------------------
    // source to flag mapping
    // ------------------------------------------------------------
    logic [39:0] set_flat;
    logic [39:0] ack_flat;

    always_comb begin
        set_flat = 40'h00_0000_0000;
        ack_flat = 40'h00_0000_0000;
        for (int s = 0; s < mire_pkg::NUM_SRC; s++) begin
            set_flat[mire_pkg::SRC_POS[s]] = src_event[s];
            if (int_ack && (vec_q == 5'(s))) begin
                ack_flat[mire_pkg::SRC_POS[s]] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // in-service levels
    // ------------------------------------------------------------
    wire         svc_any = |svc_q;
    wire [1:0]   svc_lvl = svc_q[2] ? 2'h2 : (svc_q[1] ? 2'h1 : 2'h0);
    // only the innermost level leaves on return
    wire [2:0]   svc_pop = svc_q[2] ? 3'b011 : (svc_q[1] ? 3'b101 : 3'b110);
    wire [2:0]   svc_push = 3'b001 << lvl_q;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic        best_ok;
    logic [4:0]  best_idx;
    logic [1:0]  best_lvl;
    logic [1:0]  lv;
    logic        elig;

    always_comb begin
        best_ok  = 1'b0;
        best_idx = 5'h00;
        best_lvl = 2'h0;
        lv       = 2'h0;
        elig     = 1'b0;
        // walk downward so ties settle on the lowest vector
        for (int s = mire_pkg::NUM_SRC - 1; s >= 0; s--) begin
            // code 3 would be a fourth level; fold it into the top one
            lv = (prio_q[2*s +: 2] > mire_pkg::LVL_MAX) ? mire_pkg::LVL_MAX : prio_q[2*s +: 2];
            elig = req_q[mire_pkg::SRC_POS[s]] & en_q[mire_pkg::SRC_POS[s]]
                 & (!nest_q | !svc_any | (lv > svc_lvl));
            if (elig && (!best_ok || (lv >= best_lvl))) begin
                best_ok  = 1'b1;
                best_idx = 5'(s);
                best_lvl = lv;
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // hardware set wins over program write and over acceptance
    assign req_d  = (((req_q & ~req_wmask) | (wdata_40 & req_wmask)) & ~ack_flat) | set_flat;
    assign en_d   = (en_q & ~en_wmask) | (wdata_40 & en_wmask);
    assign prio_d = (prio_q & ~prio_wmask) | (wdata_48 & prio_wmask);
    assign nest_d = wr_ctrl ? reg_wdata[mire_pkg::CTRL_NEST_BIT] : nest_q;

    // acceptance beats a program write to the master enable
    assign mie_d  = int_ack ? 1'b0 :
                    (return_from_interrupt ? 1'b1 :
                    (wr_ctrl ? reg_wdata[mire_pkg::CTRL_MIE_BIT] : mie_q));

    assign svc_d  = (int_ack && nest_q) ? (svc_q | svc_push) :
                    ((return_from_interrupt && nest_q) ? (svc_q & svc_pop) : svc_q);

    // cpu is busy saving or restoring context; nothing is offered meanwhile
    assign busy_d = int_ack ? mire_pkg::ENTRY_CYCLES :
                    (return_from_interrupt ? mire_pkg::RETURN_CYCLES :
                    ((busy_q != 4'h0) ? (busy_q - 4'h1) : 4'h0));

    wire         offer_d = mie_q & best_ok & (busy_q == 4'h0) & !int_ack & !return_from_interrupt;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [39:0]  req_rd_sh  = (req_q & mire_pkg::FLAG_IMPL) >> req_sh;
    wire [39:0]  en_rd_sh   = (en_q & mire_pkg::FLAG_IMPL) >> en_sh;
    wire [47:0]  prio_rd_sh = prio_q >> prio_sh;
    wire [7:0]   ones_req   = (req_off[2:0] == 3'h4) ? mire_pkg::REG4_ONES : 8'h00;
    wire [7:0]   ones_en    = (en_off[2:0] == 3'h4) ? mire_pkg::REG4_ONES : 8'h00;
    wire [7:0]   ctrl_rd    = {6'h00, mie_q, nest_q};
    wire [7:0]   stat_rd    = {4'h0, int_req_q, svc_q};
    wire [7:0]   rd_sel     = in_req  ? (req_rd_sh[7:0] | ones_req) :
                              in_en   ? (en_rd_sh[7:0] | ones_en) :
                              in_prio ? prio_rd_sh[7:0] :
                              in_ctrl ? ctrl_rd :
                              in_stat ? stat_rd : 8'h00;

    // ------------------------------------------------------------
    // flag and enable storage
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            req_q  <= mire_pkg::RST_FLAGS;
            en_q   <= mire_pkg::RST_FLAGS;
            prio_q <= mire_pkg::RST_PRIO;
        end else if (soft_rst) begin
            req_q  <= mire_pkg::RST_FLAGS;
            en_q   <= mire_pkg::RST_FLAGS;
            prio_q <= mire_pkg::RST_PRIO;
        end else begin
            req_q  <= req_d;
            en_q   <= en_d;
            prio_q <= prio_d;
        end
    end

    // ------------------------------------------------------------
    // control and nesting state
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            nest_q <= 1'b0;
            mie_q  <= 1'b0;
            svc_q  <= mire_pkg::RST_SVC;
            busy_q <= 4'h0;
        end else if (soft_rst) begin
            nest_q <= 1'b0;
            mie_q  <= 1'b0;
            svc_q  <= mire_pkg::RST_SVC;
            busy_q <= 4'h0;
        end else begin
            nest_q <= nest_d;
            mie_q  <= mie_d;
            svc_q  <= svc_d;
            busy_q <= busy_d;
        end
    end

    // ------------------------------------------------------------
    // cpu request and read data
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            int_req_q <= 1'b0;
            vec_q     <= 5'h00;
            lvl_q     <= 2'h0;
            rdata_q   <= 8'h00;
        end else begin
            int_req_q <= offer_d & !soft_rst;
            vec_q     <= best_idx;
            lvl_q     <= best_lvl;
            rdata_q   <= reg_rd ? rd_sel : 8'h00;
        end
    end

    assign int_req    = int_req_q;
    assign int_vector = vec_q;
    assign int_level  = lvl_q;
    assign reg_rdata  = rdata_q;

endmodule : mire_interrupt_ctrl

// ### design/mire_pkg.sv
// Purpose: constants for the maskable interrupt request and enable block
// Assumes: 8-bit register port, 24 sources in vector order
// Notes:   flag storage is one 40-bit vector, five bytes side by side

package mire_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC  = 24;
    localparam int ADDR_W   = 5;
    localparam int DATA_W   = 8;
    localparam int LVL_W    = 2;
    localparam int VEC_W    = 5;
    localparam int FLAG_W   = 40;
    localparam int PRIO_W   = 48;
    localparam int CNT_W    = 4;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_REQ0  = 5'h00;
    localparam logic [4:0] OFS_EN0   = 5'h05;
    localparam logic [4:0] OFS_PRIO0 = 5'h0A;
    localparam logic [4:0] OFS_CTRL  = 5'h10;
    localparam logic [4:0] OFS_STAT  = 5'h11;

    // ------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------
    // implemented bits of request and enable bytes 4..0
    localparam logic [39:0] FLAG_IMPL     = 40'h1F_B5_C3_CF_C3;
    localparam logic [7:0]  REG4_ONES     = 8'hE0;
    localparam logic [39:0] RST_FLAGS     = 40'h00_00_00_00_00;
    localparam logic [47:0] RST_PRIO      = 48'h0000_0000_0000;
    localparam logic [39:0] BYTE_MASK_40  = 40'h00_00_00_00_FF;
    localparam logic [47:0] BYTE_MASK_48  = 48'h0000_0000_00FF;
    localparam int          CTRL_NEST_BIT = 0;
    localparam int          CTRL_MIE_BIT  = 1;
    localparam logic [1:0]  LVL_MAX       = 2'h2;
    localparam logic [2:0]  RST_SVC       = 3'h0;

    // flat flag bit of each source, in vector address order
    localparam int SRC_POS [NUM_SRC] = '{0, 1, 6, 7, 8, 9, 10, 11, 14, 15, 16, 17,
                                         22, 23, 24, 26, 28, 29, 31, 32, 33, 34, 35, 36};

    // ------------------------------------------------------------
    // cpu sequence lengths, in clock cycles
    // ------------------------------------------------------------
    localparam logic [3:0] ENTRY_CYCLES  = 4'hE;
    localparam logic [3:0] RETURN_CYCLES = 4'hC;

endpackage : mire_pkg

// ### testbench/mire_cpu_model.sv
// Purpose: cpu core stand-in, takes offers and returns later
// Assumes: ret_wait longer than the entry sequence
// Notes:   nested takes unwind one level per ret_wait+1 cycles
`timescale 1ns/1ps
module mire_cpu_model (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       int_req,
    input  wire logic [7:0] ret_wait,
    output logic            int_ack,
    output logic            return_from_interrupt
);
    logic [7:0] cnt_q;
    logic [3:0] depth_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            int_ack               <= 1'b0;
            return_from_interrupt <= 1'b0;
            cnt_q                 <= 8'h00;
            depth_q               <= 4'h0;
        end else begin
            // never two takes in a row: the offer is still up in the cycle of a take
            int_ack               <= int_req && !int_ack;
            return_from_interrupt <= 1'b0;
            if (int_ack) begin
                depth_q <= depth_q + 4'h1;
                cnt_q   <= ret_wait;
            end else if (depth_q != 4'h0 && cnt_q == 8'h00) begin
                return_from_interrupt <= 1'b1;
                depth_q               <= depth_q - 4'h1;
                cnt_q                 <= ret_wait;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : mire_cpu_model

// ### testbench/mire_ctrl_asserts.sv
// Purpose: port checks for mire_interrupt_ctrl
// Assumes: one clock, arst_n asynchronous
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module mire_ctrl_asserts (
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic [4:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       break_instruction,
    input wire logic       watchdog_overflow,
    input wire logic       opcode_trap,
    input wire logic       int_ack,
    input wire logic       return_from_interrupt,
    input wire logic       int_req,
    input wire logic [4:0] int_vector,
    input wire logic [1:0] int_level
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // entry and return sequences keep offers quiet
    sequence quiet_entry;
        (!int_req)[*8] ##1 (!int_req)[*6];
    endsequence
    sequence quiet_ret;
        (!int_req)[*8] ##1 (!int_req)[*4];
    endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    top_ones_a: assert property ($past(reg_rd) && $past(reg_addr) inside {5'h04, 5'h09} |-> reg_rdata[7:5] == 3'h7)
        else $error("byte 4 top bits not one");
    gap_zero_a: assert property ($past(reg_rd) && $past(reg_addr) inside {5'h00, 5'h05} |-> reg_rdata[5:2] == 4'h0)
        else $error("byte 0 gap bits not zero");
    unmapped_zero_a: assert property (reg_rd && reg_addr == 5'h15 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    entry_quiet_a: assert property (int_ack |=> quiet_entry)
        else $error("offer during entry");
    return_quiet_a: assert property (return_from_interrupt |=> quiet_ret)
        else $error("offer during return");
    soft_reset_a: assert property (break_instruction || watchdog_overflow || opcode_trap |=> !int_req)
        else $error("offer after soft reset");
    offer_range_a: assert property (int_req |-> int_vector <= 5'd23 && int_level != 2'h3)
        else $error("offer vector or level out of range");
endmodule : mire_ctrl_asserts

// ### testbench/testbench.sv
// Purpose: self-checking bench for mire_interrupt_ctrl
// Assumes: register port with one-cycle read latency
// Notes:   expected reads and takes queue up in issue order
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [23:0] src_event = 24'h000000;
    logic [2:0]  cause = 3'h0;
    logic [7:0]  ret_wait = 8'h14;
    logic [7:0]  reg_rdata;
    logic        int_ack, return_from_interrupt, int_req, rd_seen;
    logic [4:0]  int_vector;
    logic [1:0]  int_level;
    logic [7:0]  exp_rd[$];
    logic [6:0]  exp_vec[$];
    logic [7:0]  rd_exp;
    logic [6:0]  vec_exp;
    logic [39:0] m40;
    logic [23:0] ev, en;
    logic [47:0] pr;
    int          errors = 0;
    int          checks_done = 0;
    always #20 clock = ~clock;
    mire_interrupt_ctrl i_mire_interrupt_ctrl (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .src_event, .break_instruction(cause[0]), .watchdog_overflow(cause[1]), .opcode_trap(cause[2]),
        .int_ack, .return_from_interrupt, .int_req, .int_vector, .int_level);
    mire_cpu_model i_mire_cpu_model (.clock, .arst_n, .int_req, .ret_wait, .int_ack, .return_from_interrupt);
    always @(posedge clock) begin
        rd_seen <= reg_rd;
        if (rd_seen === 1'b1) begin
            rd_exp = exp_rd.pop_front();
            `CHK(reg_rdata, rd_exp)
        end
        if (int_ack === 1'b1 && exp_vec.size() == 0) `CHK(int_ack, 1'b0)
        if (int_ack === 1'b1 && exp_vec.size() != 0) begin
            vec_exp = exp_vec.pop_front();
            `CHK({int_level, int_vector}, vec_exp)
        end
    end
    task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
    endtask : bus
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 5'h00, 8'h00);
    endtask : idle
    task automatic wr(input int a, input logic [7:0] d);
        bus(1'b1, 1'b0, 5'(a), d);
    endtask : wr
    task automatic rd(input int a, input logic [7:0] e);
        exp_rd.push_back(e);
        bus(1'b0, 1'b1, 5'(a), 8'h00);
    endtask : rd
    // five flag bytes; byte 4 top bits always read one
    task automatic rd5(input int base, input logic [39:0] v);
        for (int b = 0; b < 5; b++) rd(base + b, v[8*b+:8] | (b == 4 ? mire_pkg::REG4_ONES : 8'h00));
    endtask : rd5
    task automatic fire(input logic [23:0] m);
        src_event <= m;
        idle(1);
        src_event <= 24'h000000;
    endtask : fire
    task automatic wait_drain(input int n);
        for (int i = 0; i < n && exp_vec.size() != 0; i++) idle(1);
        `CHK(exp_vec.size(), 0)
    endtask : wait_drain
    task automatic done(input int n);
        idle(2);
        $display("test %0d done", n);
    endtask : done
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    function automatic logic [39:0] map40(input logic [23:0] s);
        map40 = 40'h0;
        for (int i = 0; i < 24; i++) if (s[i]) map40[mire_pkg::SRC_POS[i]] = 1'b1;
    endfunction : map40
    function automatic logic [1:0] lvl(input int s);
        lvl = (pr[2*s+:2] == 2'h3) ? 2'h2 : pr[2*s+:2];
    endfunction : lvl
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hB4E023E3));
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        rd5(0, 40'h0);
        rd5(5, 40'h0);
        done(1);
        m40 = 40'({$urandom, $urandom});
        for (int b = 0; b < 10; b++) wr(b, m40[8*(b%5)+:8]);
        wr(5'h15, 8'hFF);
        rd(5'h15, 8'h00);
        rd5(0, m40 & mire_pkg::FLAG_IMPL);
        rd5(5, m40 & mire_pkg::FLAG_IMPL);
        for (int b = 0; b < 10; b++) wr(b, 8'h00);
        done(2);
        for (int s = 0; s < 24; s++) begin
            fire(24'h1 << s);
            rd5(0, map40(24'h1 << s));
            wr(mire_pkg::SRC_POS[s] / 8, 8'h00);
        end
        src_event <= 24'h000001;
        wr(5'h00, 8'h00);
        src_event <= 24'h000000;
        rd(5'h00, 8'h01);
        wr(5'h00, 8'h00);
        done(3);
        for (int r = 0; r < 3; r++) begin
            ev = 24'($urandom);
            en = 24'($urandom);
            pr = 48'({$urandom, $urandom});
            for (int b = 0; b < 6; b++) wr(10 + b, pr[8*b+:8]);
            for (int b = 0; b < 6; b++) rd(10 + b, pr[8*b+:8]);
            m40 = map40(en);
            for (int b = 0; b < 5; b++) wr(5 + b, m40[8*b+:8]);
            fire(ev);
            for (int l = 2; l >= 0; l--)
                for (int s = 0; s < 24; s++) if (ev[s] && en[s] && lvl(s) == l) exp_vec.push_back({2'(l), 5'(s)});
            wr(5'h10, 8'h02);
            wait_drain(3000);
            rd5(0, map40(ev & ~en));
            idle(40);
            for (int b = 0; b < 10; b++) wr(b, 8'h00);
            wr(5'h10, 8'h00);
        end
        done(4);
        ret_wait <= 8'hC8;
        wr(5'h0A, 8'h05);
        wr(5'h0B, 8'h02);
        wr(5'h05, 8'h03);
        wr(5'h06, 8'h01);
        wr(5'h10, 8'h03);
        exp_vec.push_back(7'h20);
        fire(24'h000001);
        idle(6);
        wr(5'h10, 8'h03);
        // equal level must wait: any take here is unexpected
        fire(24'h000002);
        idle(60);
        rd(5'h10, 8'h03);
        rd(5'h11, 8'h02);
        exp_vec.push_back(7'h44);
        exp_vec.push_back(7'h21);
        fire(24'h000010);
        wait_drain(1500);
        ret_wait <= 8'h14;
        idle(220);
        rd(5'h10, 8'h03);
        rd(5'h11, 8'h00);
        // nesting off: a lower level nests before the return
        wr(5'h10, 8'h02);
        exp_vec.push_back(7'h44);
        fire(24'h000010);
        idle(6);
        wr(5'h10, 8'h02);
        exp_vec.push_back(7'h20);
        fire(24'h000001);
        idle(12);
        rd(5'h00, 8'h00);
        wait_drain(100);
        idle(60);
        wr(5'h10, 8'h00);
        done(5);
        for (int c = 0; c < 3; c++) begin
            wr(5'h00, 8'hC3);
            wr(5'h05, 8'hC3);
            cause <= 3'(1 << c);
            idle(1);
            cause <= 3'h0;
            rd5(0, 40'h0);
            rd5(5, 40'h0);
        end
        done(6);
        complete_run();
    end
endmodule : testbench
bind mire_interrupt_ctrl mire_ctrl_asserts i_mire_ctrl_asserts (.clock, .arst_n, .reg_addr, .reg_rd, .reg_rdata,
    .break_instruction, .watchdog_overflow, .opcode_trap, .int_ack, .return_from_interrupt, .int_req,
    .int_vector, .int_level);
